// ---- include/psrs_pkg.sv ----
package psrs_pkg;
  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL          = 12'h000;
  localparam logic [11:0] ADDR_STATUS        = 12'h004;
  // Control register fields and reset value
  localparam int          CTRL_SOFT_RST_BIT  = 0;
  localparam logic        CTRL_SOFT_RST_RST  = 1'b1;
  // Status register fields
  localparam int          STS_PIN_BIT        = 0;
  localparam int          STS_FAULT_BIT      = 1;
  localparam int          STS_RATIO_BIT      = 2;
  localparam int          STS_LATE_BIT       = 3;
  localparam int          STS_STATE_LSB      = 4;
  // Timing
  localparam int          CORE_CLK_HZ        = 25_000_000;
  localparam int          REG_UP_TIME_US     = 5000;
  localparam int          REG_UP_CYC         = REG_UP_TIME_US * (CORE_CLK_HZ / 1_000_000);
  localparam int          START_LIMIT_MS     = 32;
  localparam int          START_LIMIT_CYC    = START_LIMIT_MS * (CORE_CLK_HZ / 1000);
  localparam logic [3:0]  RATIO_PERIODS      = 4'h8;
  localparam int          GROUP_DELAY_PERIODS = 204;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_PD,
    ST_REG_UP,
    ST_WAIT_EDGE,
    ST_RATIO,
    ST_GDELAY,
    ST_NORMAL,
    ST_SOFTRST,
    ST_FAULT
  } psrs_state_t;
endpackage : psrs_pkg

// ---- include/psrs_sync_if.sv ----
`timescale 1ns/1ps
interface psrs_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;    // Pin levels before the chain
  logic [W-1:0] level;  // Agreed level
  logic [W-1:0] rise;   // One-cycle pulse on an agreed rise
  modport sync (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface : psrs_sync_if

// ---- rtl/psrs_sync.sv ----
`timescale 1ns/1ps
module psrs_sync #(
  parameter int W = 1
) (
  input  wire logic    core_clk,  // Core clock
  input  wire logic    resetn,    // Synchronous reset, active low
  input  wire logic    clrN,      // Asynchronous clear, active low
  psrs_sync_if.sync    sif        // Raw pins in, agreed levels out
);
  typedef struct packed {
    logic [W-1:0] s1;     // First stage, read only by the second
    logic [W-1:0] s2;     // Second stage
    logic [W-1:0] s3;     // Third stage
    logic [W-1:0] level;  // Agreed level
    logic [W-1:0] rise;   // Rise pulse
  } psrs_sync_t;

  psrs_sync_t st_r;   // Registered state
  psrs_sync_t st_nxt; // Next state

  // A change counts once stages two and three agree; each bit on its own
  always_comb begin
    st_nxt       = st_r;
    st_nxt.s1    = sif.raw;
    st_nxt.s2    = st_r.s1;
    st_nxt.s3    = st_r.s2;
    st_nxt.level = (st_r.s3 & ~(st_r.s2 ^ st_r.s3)) | (st_r.level & (st_r.s2 ^ st_r.s3)); // Hold while stages differ
    st_nxt.rise  = st_r.s2 & st_r.s3 & ~st_r.level;
  end

  // Clear acts at once; release waits for the chain
  always_ff @(posedge core_clk or negedge clrN) begin
    if (!clrN) begin
      st_r <= '0;
    end else if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sif.level = st_r.level;
  assign sif.rise  = st_r.rise;
endmodule : psrs_sync

// ---- rtl/psrs_sequencer.sv ----
`timescale 1ns/1ps
module psrs_sequencer #(
  parameter int REG_UP_CYC      = psrs_pkg::REG_UP_CYC,     // Regulator start-up cycles
  parameter int START_LIMIT_CYC = psrs_pkg::START_LIMIT_CYC // Longest start-up cycles
) (
  input  wire logic        core_clk,             // 25 MHz core clock
  input  wire logic        resetn,               // Synchronous reset, active low
  input  wire logic [11:0] paddr,                // APB address
  input  wire logic        psel,                 // APB select
  input  wire logic        penable,              // APB enable
  input  wire logic        pwrite,               // APB direction
  input  wire logic [31:0] pwdata,               // APB write data
  output logic      [31:0] prdata,               // APB read data
  output logic             pready,               // APB ready
  output logic             pslverr,              // APB error
  input  wire logic        power_down_n,         // Power-down pin, active low
  input  wire logic        input_frame_clock,    // Input frame clock pin
  input  wire logic        outputFrameClock,     // Output frame clock pin
  input  wire logic        control_mode_select,  // Low selects serial control
  input  wire logic        regFault,             // Regulator over-current/voltage flag
  input  wire logic        coreAudioData,        // Converted serial data from core
  output logic             serial_audio_out,     // Serial audio output
  output logic             converter_status_pin, // Status pin
  output logic             regulatorEnable,      // Internal regulator on
  output logic             coreEnable,           // Converter core powered
  output logic             filterInit            // Filter state held in init
);
  localparam int CW = ($clog2(REG_UP_CYC + 1) > 8) ? $clog2(REG_UP_CYC + 1) : 8; // Phase counter width
  localparam int SW = $clog2(START_LIMIT_CYC + 1);                           // Start watchdog width
  localparam logic [CW-1:0] REG_LAST = CW'(REG_UP_CYC - 1);                  // Last regulator cycle
  localparam logic [CW-1:0] GD_LAST  = CW'(psrs_pkg::GROUP_DELAY_PERIODS - 1); // Last group-delay period
  localparam logic [SW-1:0] LATE_AT  = SW'(START_LIMIT_CYC);                 // Start-up overrun point

  typedef struct packed {
    psrs_pkg::psrs_state_t state;     // Sequencer state
    logic [CW-1:0]         cnt;       // Phase counter
    logic [3:0]            inCnt;     // Input frame periods seen
    logic [3:0]            outCnt;    // Output frame periods seen
    logic [SW-1:0]         startCnt;  // Start-up watchdog
    logic                  ratioDone; // Ratio detection complete
    logic                  fault;     // Regulator fault latched
    logic                  late;      // Start-up overran its limit
    logic                  softRstN;  // Register reset bit
    logic                  serOut;    // Audio output
    logic                  statusPin; // Status pin
    logic                  regEn;     // Regulator enable
    logic                  coreEn;    // Core enable
    logic                  filtInit;  // Filter init
    logic                  pready;    // APB ready
    logic                  pslverr;   // APB error
    logic [31:0]           prdata;    // APB read data
  } psrs_regs_t;

  psrs_regs_t st_r;   // Registered state
  psrs_regs_t st_nxt; // Next state

  // Synchronised pins
  psrs_sync_if #(.W(1)) pdnIf ();
  psrs_sync_if #(.W(4)) pinIf ();
  assign pdnIf.raw = power_down_n;
  assign pinIf.raw = {regFault, control_mode_select, outputFrameClock, input_frame_clock};

  // Power-down clears its chain at once, release passes four flops
  psrs_sync #(.W(1)) u_pdnSync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clrN     (power_down_n),
    .sif      (pdnIf)
  );

  psrs_sync #(.W(4)) u_pinSync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clrN     (1'b1),
    .sif      (pinIf)
  );

  logic pdnLvl;    // Device out of power-down
  logic inRise;    // Input frame clock rising
  logic outRise;   // Output frame clock rising
  logic serialCtl; // Serial control mode
  logic faultLvl;  // Regulator fault seen
  logic apbAccess; // Completing APB access
  assign pdnLvl    = pdnIf.level[0];
  assign inRise    = pinIf.rise[0];
  assign outRise   = pinIf.rise[1];
  assign serialCtl = ~pinIf.level[2];
  assign faultLvl  = pinIf.level[3];
  assign apbAccess = psel & penable & st_r.pready;

  // Sequencer, register file and outputs
  always_comb begin
    st_nxt         = st_r;
    st_nxt.pready  = psel & ~penable & ~st_r.pready;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata  = '0;
    // APB setup: decode and prepare the answer
    if (psel && !penable && !st_r.pready) begin
      if (paddr == psrs_pkg::ADDR_CTRL) begin
        st_nxt.prdata[psrs_pkg::CTRL_SOFT_RST_BIT] = st_r.softRstN;
      end else if (paddr == psrs_pkg::ADDR_STATUS) begin
        st_nxt.prdata[psrs_pkg::STS_PIN_BIT]          = st_r.statusPin;
        st_nxt.prdata[psrs_pkg::STS_FAULT_BIT]        = st_r.fault;
        st_nxt.prdata[psrs_pkg::STS_RATIO_BIT]        = st_r.ratioDone;
        st_nxt.prdata[psrs_pkg::STS_LATE_BIT]         = st_r.late;
        st_nxt.prdata[psrs_pkg::STS_STATE_LSB +: 3]   = st_r.state;
        st_nxt.pslverr = pwrite;
      end else begin
        st_nxt.pslverr = 1'b1;
      end
    end
    // APB access: write takes effect
    if (apbAccess && pwrite && paddr == psrs_pkg::ADDR_CTRL) begin
      st_nxt.softRstN = pwdata[psrs_pkg::CTRL_SOFT_RST_BIT];
    end
    if (!pdnLvl) begin
      // Power-down: sequencer state, counters, flags and reset bit back to their initial values
      st_nxt.state     = psrs_pkg::ST_PD;
      st_nxt.cnt       = '0;
      st_nxt.inCnt     = '0;
      st_nxt.outCnt    = '0;
      st_nxt.startCnt  = '0;
      st_nxt.ratioDone = 1'b0;
      st_nxt.fault     = 1'b0;
      st_nxt.late      = 1'b0;
      st_nxt.softRstN  = psrs_pkg::CTRL_SOFT_RST_RST;
    end else begin
      case (st_r.state)
        psrs_pkg::ST_PD: begin
          st_nxt.state = psrs_pkg::ST_REG_UP;
          st_nxt.cnt   = '0;
        end
        psrs_pkg::ST_REG_UP: begin
          // Wait out regulator start-up
          st_nxt.cnt = st_r.cnt + 1'b1;
          if (st_r.cnt == REG_LAST) begin
            st_nxt.state = psrs_pkg::ST_WAIT_EDGE;
          end
        end
        psrs_pkg::ST_WAIT_EDGE: begin
          // Core wakes on an input frame edge
          if (inRise) begin
            st_nxt.state  = psrs_pkg::ST_RATIO;
            st_nxt.inCnt  = '0;
            st_nxt.outCnt = '0;
          end
        end
        psrs_pkg::ST_RATIO: begin
          // Eight periods of both clocks covers the slower one
          if (inRise && st_r.inCnt != psrs_pkg::RATIO_PERIODS) begin
            st_nxt.inCnt = st_r.inCnt + 1'b1;
          end
          if (outRise && st_r.outCnt != psrs_pkg::RATIO_PERIODS) begin
            st_nxt.outCnt = st_r.outCnt + 1'b1;
          end
          if (st_r.inCnt == psrs_pkg::RATIO_PERIODS && st_r.outCnt == psrs_pkg::RATIO_PERIODS) begin
            st_nxt.state     = psrs_pkg::ST_GDELAY;
            st_nxt.ratioDone = 1'b1;
            st_nxt.cnt       = '0;
          end
        end
        psrs_pkg::ST_GDELAY: begin
          // Group delay in output periods
          if (outRise) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (st_r.cnt == GD_LAST) begin
              st_nxt.state = psrs_pkg::ST_NORMAL;
            end
          end
        end
        psrs_pkg::ST_SOFTRST: begin
          // Regulator stays up, restart from the frame edge
          if (st_r.softRstN || !serialCtl) begin
            st_nxt.state = psrs_pkg::ST_WAIT_EDGE;
          end
        end
        psrs_pkg::ST_FAULT: begin
          // Only a power-down pulse leaves here
          st_nxt.state = psrs_pkg::ST_FAULT;
        end
        default: begin
          st_nxt.state = st_r.state;
        end
      endcase
      // Register reset bit acts in serial control mode only
      if (serialCtl && !st_r.softRstN && st_r.state != psrs_pkg::ST_PD && st_r.state != psrs_pkg::ST_REG_UP
          && st_r.state != psrs_pkg::ST_FAULT) begin
        st_nxt.state     = psrs_pkg::ST_SOFTRST;
        st_nxt.ratioDone = 1'b0;
        st_nxt.startCnt  = '0;
      end
      // Regulator fault wins over everything else except power-down and the ST_PD state
      if (faultLvl && st_r.state != psrs_pkg::ST_PD) begin
        st_nxt.state     = psrs_pkg::ST_FAULT;
        st_nxt.fault     = 1'b1;
        st_nxt.ratioDone = 1'b0;
      end
      // Start-up watchdog flags an overrun
      if (st_nxt.state != psrs_pkg::ST_NORMAL && st_nxt.state != psrs_pkg::ST_SOFTRST
          && st_nxt.state != psrs_pkg::ST_FAULT && st_r.startCnt != LATE_AT) begin
        st_nxt.startCnt = st_r.startCnt + 1'b1;
      end
      if (st_r.startCnt == LATE_AT && st_r.state != psrs_pkg::ST_NORMAL) begin
        st_nxt.late = 1'b1;
      end
    end
    // Outputs follow the next state so they come from flops in step
    st_nxt.serOut    = (st_nxt.state == psrs_pkg::ST_NORMAL) ? coreAudioData : 1'b0;
    st_nxt.statusPin = st_nxt.fault | ~st_nxt.ratioDone;
    st_nxt.regEn     = (st_nxt.state != psrs_pkg::ST_PD) && (st_nxt.state != psrs_pkg::ST_FAULT);
    st_nxt.coreEn    = (st_nxt.state == psrs_pkg::ST_RATIO) || (st_nxt.state == psrs_pkg::ST_GDELAY)
                       || (st_nxt.state == psrs_pkg::ST_NORMAL);
    st_nxt.filtInit  = ~st_nxt.coreEn;
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_r          <= '0;
      st_r.state    <= psrs_pkg::ST_PD;
      st_r.softRstN <= psrs_pkg::CTRL_SOFT_RST_RST;
      st_r.statusPin <= 1'b1;
      st_r.filtInit <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata               = st_r.prdata;
  assign pready               = st_r.pready;
  assign pslverr              = st_r.pslverr;
  assign serial_audio_out     = st_r.serOut;
  assign converter_status_pin = st_r.statusPin;
  assign regulatorEnable      = st_r.regEn;
  assign coreEnable           = st_r.coreEn;
  assign filterInit           = st_r.filtInit;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_out_low_pd: assert property (!pdnLvl |=> !serial_audio_out)
    else $error("audio output not low in power-down");
  a_status_pd: assert property (!pdnLvl |=> converter_status_pin)
    else $error("status pin not high in power-down");
  a_filter_pd: assert property (!pdnLvl |=> filterInit && !coreEnable)
    else $error("filter not held in init during power-down");
  a_out_normal: assert property (serial_audio_out |-> st_r.state == psrs_pkg::ST_NORMAL)
    else $error("audio output active outside normal state");
  a_normal_ready: assert property (st_r.state == psrs_pkg::ST_NORMAL |-> st_r.ratioDone && !st_r.fault
                                   && regulatorEnable)
    else $error("normal state without ratio detection or regulator");
  a_core_edge: assert property ($rose(coreEnable) |-> $past(inRise))
    else $error("core powered without input frame edge");
  a_status_or: assert property (converter_status_pin == (st_r.fault || !st_r.ratioDone))
    else $error("status pin is not fault OR not-detected");
  // The pin clears its level between edges, so a pulse may end the hold one edge early
  a_fault_hold: assert property (st_r.fault && pdnLvl |=> !pdnLvl
                                 || (st_r.fault && st_r.state == psrs_pkg::ST_FAULT))
    else $error("fault released without power-down pulse");
  a_soft_reg: assert property (st_r.state == psrs_pkg::ST_SOFTRST |-> regulatorEnable)
    else $error("regulator off during register reset");
  a_normal_from: assert property (st_r.state == psrs_pkg::ST_NORMAL
                                  |-> $past(st_r.state) == psrs_pkg::ST_NORMAL
                                  || $past(st_r.state) == psrs_pkg::ST_GDELAY)
    else $error("normal state entered out of order");
endmodule : psrs_sequencer

// ---- sim/psrs_host_model.sv ----
`timescale 1ns/1ps
// Host side: drives the power-down pin, the mode pin and both frame clocks
module psrs_host_model #(
  parameter int IN_HALF  = 5, // Input frame half period, core cycles
  parameter int OUT_HALF = 4  // Output frame half period, core cycles
) (
  input  wire logic core_clk,            // Core clock
  input  wire logic pdnReq,              // High asks power-down released
  input  wire logic inRun,               // Input frame clock runs
  input  wire logic outRun,              // Output frame clock runs
  input  wire logic modeReq,             // Wanted control mode level
  output logic      power_down_n,        // Power-down pin
  output logic      input_frame_clock,   // Input frame clock pin
  output logic      outputFrameClock,    // Output frame clock pin
  output logic      control_mode_select  // Control mode pin
);
  int inCnt;  // Input half-period count
  int outCnt; // Output half-period count
  // Power is applied with the pin low, so the device starts from reset
  initial begin
    power_down_n = 1'b0;
    input_frame_clock = 1'b0;
    outputFrameClock = 1'b0;
    control_mode_select = 1'b0;
    inCnt = 0;
    outCnt = 0;
  end
  // Pin follows the bench; the mode pin moves only inside power-down
  always @(posedge core_clk) begin
    power_down_n <= pdnReq;
    if (!power_down_n && !pdnReq) begin
      control_mode_select <= modeReq;
    end
  end
  // Frame clocks stand still while stopped; both run well below core/4
  always @(posedge core_clk) begin
    if (inRun) begin
      inCnt <= (inCnt == IN_HALF - 1) ? 0 : inCnt + 1;
      input_frame_clock <= (inCnt == IN_HALF - 1) ? ~input_frame_clock : input_frame_clock;
    end
    if (outRun) begin
      outCnt <= (outCnt == OUT_HALF - 1) ? 0 : outCnt + 1;
      outputFrameClock <= (outCnt == OUT_HALF - 1) ? ~outputFrameClock : outputFrameClock;
    end
  end
endmodule : psrs_host_model

// ---- sim/psrs_sequencer_tb.sv ----
`timescale 1ns/1ps
module psrs_sequencer_tb;
  localparam int REG_UP = 300;        // Shortened regulator start-up
  localparam int START_LIM = 4000;    // Shortened start-up limit
  localparam logic [9:0] PAT = 10'h2D3; // Pass-through pattern
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;       // APB address
  logic [31:0] pwdata, prdata; // APB data
  logic power_down_n, input_frame_clock, outputFrameClock, control_mode_select;
  logic regFault, coreAudioData, serial_audio_out, converter_status_pin;
  logic regulatorEnable, coreEnable, filterInit;
  logic pdnReq, inRun, outRun, modeReq; // Host model requests
  logic watchZero;          // Output must stay low while set
  int failCount = 0;        // Mismatches
  int totalChecks = 0;      // Comparisons
  int outRises = 0;         // Raw output frame rises
  int cycles = 0;           // Timeout count
  psrs_sequencer #(.REG_UP_CYC(REG_UP), .START_LIMIT_CYC(START_LIM)) dut (
    .core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down_n(power_down_n), .input_frame_clock(input_frame_clock),
    .outputFrameClock(outputFrameClock), .control_mode_select(control_mode_select),
    .regFault(regFault), .coreAudioData(coreAudioData), .serial_audio_out(serial_audio_out),
    .converter_status_pin(converter_status_pin), .regulatorEnable(regulatorEnable),
    .coreEnable(coreEnable), .filterInit(filterInit));
  psrs_host_model host (
    .core_clk(core_clk), .pdnReq(pdnReq), .inRun(inRun), .outRun(outRun), .modeReq(modeReq),
    .power_down_n(power_down_n), .input_frame_clock(input_frame_clock),
    .outputFrameClock(outputFrameClock), .control_mode_select(control_mode_select));
  // 25 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge outputFrameClock) outRises <= outRises + 1;
  // Output held low outside normal operation
  always @(posedge core_clk) begin
    if (watchZero) begin
      chk_bit(serial_audio_out, 1'b0, "output not low");
    end
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failCount++;
      conclude();
    end
  end
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: %s got %h", $time, msg, got);
    end
  endtask : chk_word
  task automatic chk_range(input int got, input int lo, input int hi, input string msg);
    totalChecks++;
    if (got < lo || got > hi) begin
      failCount++;
      $display("mismatch at %0t: %s got %0d", $time, msg, got);
    end
  endtask : chk_range
  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    chk_bit(pready, 1'b1, "no ready");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic reg_read(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    logic e;
    apb(a, 1'b0, 32'h0000_0000, q, e);
    chk_bit(e, 1'b0, "read error");
    chk_word(q & m, exp, "register value");
  endtask : reg_read
  task automatic wait_out(input int lim, output int n);
    n = 0;
    while (serial_audio_out !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk_bit(serial_audio_out, 1'b1, "output never started");
  endtask : wait_out
  task automatic t_reset;
    @(posedge core_clk);
    chk_bit(converter_status_pin, 1'b1, "status in power-down");
    chk_bit(filterInit, 1'b1, "filter not held");
    chk_bit(regulatorEnable, 1'b0, "regulator on");
    reg_read(psrs_pkg::ADDR_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
    reg_read(psrs_pkg::ADDR_STATUS, 32'h0000_0001, 32'hFFFF_FFFF);
  endtask : t_reset
  // Release from power-down and follow the sequence into normal data
  task automatic t_powerup;
    int n;
    int m;
    int r0;
    pdnReq <= 1'b1;
    n = 0;
    while (converter_status_pin !== 1'b0 && n < START_LIM) begin
      @(posedge core_clk);
      n++;
    end
    watchZero = 1'b0;
    r0 = outRises;
    wait_out(START_LIM, m);
    chk_range(outRises - r0, 203, 205, "group delay frames");
    chk_range(n + m, REG_UP + 5, START_LIM - 1, "start-up time");
    reg_read(psrs_pkg::ADDR_STATUS, 32'h0000_0054, 32'hFFFF_FFFF);
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      if (i >= 2) begin
        chk_bit(serial_audio_out, PAT[i-2], "pass-through");
      end
      coreAudioData <= PAT[i];
    end
    coreAudioData <= 1'b1;
  endtask : t_powerup
  task automatic power_cycle;
    coreAudioData <= 1'b0;
    pdnReq <= 1'b0;
    watchZero = 1'b1;
    repeat (6) @(posedge core_clk);
    coreAudioData <= 1'b1;
    t_powerup();
  endtask : power_cycle
  // Register-bit reset keeps the regulator and skips its start-up wait
  task automatic t_softrst;
    logic [31:0] q;
    logic e;
    int n;
    apb(psrs_pkg::ADDR_CTRL, 1'b1, 32'h0000_0000, q, e);
    // The bit lands at the access edge; the output drops one edge later
    repeat (2) @(posedge core_clk);
    watchZero = 1'b1;
    repeat (2) @(posedge core_clk);
    chk_bit(coreEnable, 1'b0, "core still on");
    chk_bit(regulatorEnable, 1'b1, "regulator dropped");
    reg_read(psrs_pkg::ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    reg_read(psrs_pkg::ADDR_STATUS, 32'h0000_0061, 32'h0000_0073);
    watchZero = 1'b0;
    apb(psrs_pkg::ADDR_CTRL, 1'b1, 32'h0000_0001, q, e);
    wait_out(3000, n);
    chk_range(n, 1690, 1750, "restart latency");
  endtask : t_softrst
  // Regulator fault holds reset until the pin is pulsed
  task automatic t_fault;
    regFault <= 1'b1;
    repeat (8) @(posedge core_clk);
    watchZero = 1'b1;
    chk_bit(converter_status_pin, 1'b1, "status low in fault");
    chk_bit(regulatorEnable, 1'b0, "regulator on in fault");
    regFault <= 1'b0;
    repeat (50) @(posedge core_clk);
    reg_read(psrs_pkg::ADDR_STATUS, 32'h0000_0073, 32'h0000_0073);
    power_cycle();
  endtask : t_fault
  // No input frame edge: the core waits; then power-down in mid-sequence
  task automatic t_stall;
    int n;
    pdnReq <= 1'b0;
    @(posedge core_clk);
    inRun <= 1'b0;
    outRun <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk_bit(filterInit, 1'b1, "filter not held");
    pdnReq <= 1'b1;
    repeat (START_LIM + 100) @(posedge core_clk);
    chk_bit(coreEnable, 1'b0, "core up without edge");
    reg_read(psrs_pkg::ADDR_STATUS, 32'h0000_0029, 32'h0000_007F);
    inRun <= 1'b1;
    outRun <= 1'b1;
    n = 0;
    while (coreEnable !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    chk_range(n, 1, 39, "core start after edge");
    pdnReq <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk_bit(coreEnable, 1'b0, "core on in power-down");
    chk_bit(converter_status_pin, 1'b1, "status low in power-down");
    chk_bit(filterInit, 1'b1, "filter not held");
  endtask : t_stall
  // Parallel mode ignores the reset bit; power-down reinitialises it
  task automatic t_parallel;
    logic [31:0] q;
    logic e;
    modeReq <= 1'b1;
    watchZero = 1'b1;
    repeat (4) @(posedge core_clk);
    t_powerup();
    apb(psrs_pkg::ADDR_CTRL, 1'b1, 32'h0000_0000, q, e);
    repeat (10) @(posedge core_clk);
    chk_bit(serial_audio_out, 1'b1, "output stopped");
    coreAudioData <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk_bit(serial_audio_out, 1'b0, "muted output not low");
    pdnReq <= 1'b0;
    modeReq <= 1'b0;
    repeat (6) @(posedge core_clk);
    reg_read(psrs_pkg::ADDR_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
  endtask : t_parallel
  task automatic t_apb_err;
    logic [31:0] q;
    logic e;
    apb(12'h008, 1'b0, 32'h0000_0000, q, e);
    chk_bit(e, 1'b1, "unmapped read accepted");
    chk_word(q, 32'h0000_0000, "unmapped read data");
    apb(psrs_pkg::ADDR_STATUS, 1'b1, 32'hFFFF_FFFF, q, e);
    chk_bit(e, 1'b1, "status write accepted");
    reg_read(psrs_pkg::ADDR_STATUS, 32'h0000_0001, 32'hFFFF_FFFF);
  endtask : t_apb_err
  task automatic conclude;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    regFault = 1'b0;
    coreAudioData = 1'b1;
    pdnReq = 1'b0;
    inRun = 1'b1;
    outRun = 1'b1;
    modeReq = 1'b0;
    watchZero = 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    watchZero = 1'b1;
    t_reset();
    t_powerup();
    t_softrst();
    t_fault();
    t_stall();
    t_parallel();
    t_apb_err();
    conclude();
  end
endmodule : psrs_sequencer_tb
